// *** core/hash_region_descriptor_control.sv ***
// Purpose: walk the region descriptor list and raise per-region flags
// Assumes: hash engine and memory reader sit outside this block
`timescale 1ns/1ps
module hash_region_descriptor_control
   import integrity_monitor_pkg::*;
#(
   parameter int NUM_REGIONS = 4
) (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic mem_req_out,
   output logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in,
   input wire logic mem_err_in,
   output logic hash_start_out,
   output logic hash_compare_out,
   output logic [31:0] hash_region_out,
   input wire logic hash_done_in,
   input wire logic hash_mismatch_in,
   output logic busy_out,
   output logic irq_out
);
   localparam int RID_W = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;
   localparam int FLG_W = FLG_KINDS * NUM_REGIONS;

   // ==========================================================
   // Register bus slave
   logic awready_ff, nxt_awready;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [31:0] base_ff, nxt_base;
   logic [31:0] ien_ff, nxt_ien;
   logic start_ff, nxt_start;
   logic stop_ff, nxt_stop;
   logic [FLG_W-1:0] flags;
   logic [FLG_W-1:0] clr_vec;
   logic wr_fire, rd_fire;
   logic [31:0] wmask;

   // Walker state declared here because the slave reads it
   walk_state_t state_ff, nxt_state;
   logic [RID_W-1:0] rid_ff, nxt_rid;

   always_comb begin
      wmask = {{8{s_axi_wstrb_in[3]}}, {8{s_axi_wstrb_in[2]}},
               {8{s_axi_wstrb_in[1]}}, {8{s_axi_wstrb_in[0]}}};
      wr_fire = awready_ff && s_axi_awvalid_in;
      rd_fire = arready_ff && s_axi_arvalid_in;
      // Both write channels taken in one edge, once both are offered
      nxt_awready = !awready_ff && !bvalid_ff && s_axi_awvalid_in &&
                    s_axi_wvalid_in;
      nxt_bvalid = bvalid_ff && !s_axi_bready_in;
      nxt_bresp = bresp_ff;
      nxt_base = base_ff;
      nxt_ien = ien_ff;
      nxt_start = start_ff;
      nxt_stop = stop_ff;
      clr_vec = '0;
      if (state_ff == ST_IDLE) begin
         nxt_stop = 1'b0;
      end
      if (start_ff && state_ff == ST_IDLE) begin
         nxt_start = 1'b0;
      end
      if (wr_fire) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OKAY;
         unique case (s_axi_awaddr_in)
            CTRL_OFS: begin
               if (s_axi_wstrb_in[0]) begin
                  nxt_start = start_ff || s_axi_wdata_in[CTRL_START_BIT];
                  nxt_stop = nxt_stop || s_axi_wdata_in[CTRL_STOP_BIT];
               end
            end
            BASE_OFS: nxt_base = (base_ff & ~wmask) |
                                 (s_axi_wdata_in & wmask);
            IEN_OFS: nxt_ien = (ien_ff & ~wmask) | (s_axi_wdata_in & wmask);
            ICLR_OFS: clr_vec = FLG_W'(s_axi_wdata_in & wmask);
            STAT_OFS, STATE_OFS: nxt_bresp = RESP_OKAY;
            default: nxt_bresp = RESP_SLVERR;
         endcase
      end
      nxt_arready = !arready_ff && !rvalid_ff && s_axi_arvalid_in;
      nxt_rvalid = rvalid_ff && !s_axi_rready_in;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rd_fire) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         unique case (s_axi_araddr_in)
            CTRL_OFS: nxt_rdata[CTRL_STOP_BIT] = stop_ff;
            BASE_OFS: nxt_rdata = base_ff;
            STAT_OFS: nxt_rdata = 32'(flags);
            IEN_OFS: nxt_rdata = ien_ff;
            ICLR_OFS: nxt_rdata = 32'h0000_0000;
            STATE_OFS: nxt_rdata = {19'h0, 5'(state_ff), 8'(rid_ff)};
            default: nxt_rresp = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         awready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
         base_ff <= BASE_RST;
         ien_ff <= IEN_RST;
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         awready_ff <= nxt_awready;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         base_ff <= nxt_base;
         ien_ff <= nxt_ien;
         start_ff <= nxt_start;
         stop_ff <= nxt_stop;
      end
   end

   // ==========================================================
   // Descriptor walker
   logic [31:0] cur_ff, nxt_cur;
   logic req_ff, nxt_req;
   logic [31:0] maddr_ff, nxt_maddr;
   logic hstart_ff, nxt_hstart;
   logic next_zero_ff, nxt_next_zero;
   region_cfg_t cfg_ff, nxt_cfg;
   region_cfg_t fetched_cfg;
   logic [FLG_KINDS-1:0] evt;
   logic [FLG_KINDS-1:0] dis;

   region_cfg_decode u_decode (
      .word_in(mem_rdata_in),
      .cfg_out(fetched_cfg)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_cur = cur_ff;
      nxt_rid = rid_ff;
      nxt_req = req_ff;
      nxt_maddr = maddr_ff;
      nxt_hstart = 1'b0;
      nxt_next_zero = next_zero_ff;
      nxt_cfg = cfg_ff;
      evt = '0;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_ff) begin
               nxt_cur = base_ff;
               nxt_rid = '0;
               nxt_req = 1'b1;
               nxt_maddr = base_ff + DESC_CFG_OFS;
               nxt_state = ST_CFG;
            end
         end
         ST_CFG: begin
            if (mem_ack_in && mem_err_in) begin
               evt[FLG_BUS] = 1'b1;
               nxt_req = 1'b0;
               nxt_state = ST_IDLE;
            end else if (mem_ack_in) begin
               nxt_cfg = fetched_cfg;
               nxt_maddr = cur_ff + DESC_NEXT_OFS;
               nxt_state = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (mem_ack_in) begin
               nxt_req = 1'b0;
               if (mem_err_in) begin
                  evt[FLG_BUS] = 1'b1;
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_next_zero = (mem_rdata_in == 32'h0000_0000);
                  nxt_hstart = 1'b1;
                  nxt_state = ST_HASH;
               end
            end
         end
         ST_HASH: begin
            if (hash_done_in) begin
               evt[FLG_DONE] = next_zero_ff;
               // A mismatch only means something in compare mode
               evt[FLG_MISMATCH] = hash_mismatch_in &&
                                   cfg_ff.digest_compare_select;
               nxt_state = ST_ADV;
            end
         end
         ST_ADV: begin
            if (cfg_ff.end_of_list_marker || stop_ff) begin
               nxt_state = ST_IDLE;
            end else begin
               if (cfg_ff.list_loop) begin
                  evt[FLG_LOOP] = 1'b1;
                  nxt_cur = base_ff;
                  nxt_rid = '0;
               end else begin
                  nxt_cur = cur_ff + DESC_STRIDE;
                  nxt_rid = rid_ff + RID_W'(1);
               end
               nxt_maddr = nxt_cur + DESC_CFG_OFS;
               nxt_req = 1'b1;
               nxt_state = ST_CFG;
            end
         end
      endcase
      // Before the word arrives no disables are known, so none apply
      dis = (state_ff == ST_CFG) ? '0 :
            {cfg_ff.loop_flag_disable, cfg_ff.bus_fault_flag_disable,
             cfg_ff.mismatch_flag_disable, cfg_ff.hash_done_flag_disable};
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_ff <= ST_IDLE;
         cur_ff <= BASE_RST;
         rid_ff <= '0;
         req_ff <= 1'b0;
         maddr_ff <= 32'h0000_0000;
         hstart_ff <= 1'b0;
         next_zero_ff <= 1'b0;
         cfg_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cur_ff <= nxt_cur;
         rid_ff <= nxt_rid;
         req_ff <= nxt_req;
         maddr_ff <= nxt_maddr;
         hstart_ff <= nxt_hstart;
         next_zero_ff <= nxt_next_zero;
         cfg_ff <= nxt_cfg;
      end
   end

   // ==========================================================
   // Per-region flags and interrupt
   logic irq_ff;

   for (genvar r = 0; r < NUM_REGIONS; r++) begin : g_region
      for (genvar k = 0; k < FLG_KINDS; k++) begin : g_kind
         region_flag_cell u_flag (
            .mclk_in(mclk_in),
            .reset_in(reset_in),
            .set_in(evt[k] && (rid_ff == RID_W'(r))),
            .disable_in(dis[k]),
            .clear_in(clr_vec[k*NUM_REGIONS+r]),
            .flag_out(flags[k*NUM_REGIONS+r])
         );
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(flags & ien_ff[FLG_W-1:0]);
      end
   end

   assign s_axi_awready_out = awready_ff;
   assign s_axi_wready_out = awready_ff;
   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_arready_out = arready_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign mem_req_out = req_ff;
   assign mem_addr_out = maddr_ff;
   assign hash_start_out = hstart_ff;
   assign hash_compare_out = cfg_ff.digest_compare_select;
   assign hash_region_out = cur_ff;
   assign busy_out = (state_ff != ST_IDLE);
   assign irq_out = irq_ff;

   // ==========================================================
   // Checks
   a_compare_mode: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_CFG && mem_ack_in && !mem_err_in) |=>
         hash_compare_out == $past(mem_rdata_in[CFG_COMPARE_BIT]))
      else $error("compare select does not follow config bit");
   a_next_seq: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_ADV && !cfg_ff.end_of_list_marker && !stop_ff &&
       !cfg_ff.list_loop) |=> mem_req_out &&
         mem_addr_out == $past(cur_ff) + DESC_STRIDE + DESC_CFG_OFS)
      else $error("sequential descriptor address wrong");
   a_next_wrap: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_ADV && !cfg_ff.end_of_list_marker && !stop_ff &&
       cfg_ff.list_loop) |=> mem_addr_out == base_ff + DESC_CFG_OFS &&
         rid_ff == '0)
      else $error("loop did not return to list base");
   a_end_list: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_ADV && cfg_ff.end_of_list_marker) |=>
         (!mem_req_out && !busy_out)[*2])
      else $error("walk continued past end marker");
   a_done_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_HASH && hash_done_in && next_zero_ff &&
       !cfg_ff.hash_done_flag_disable) |=>
         flags[FLG_DONE*NUM_REGIONS + int'($past(rid_ff))])
      else $error("region done flag not set");
   a_mism_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_HASH && hash_done_in && hash_mismatch_in &&
       cfg_ff.digest_compare_select && !cfg_ff.mismatch_flag_disable) |=>
         flags[FLG_MISMATCH*NUM_REGIONS + int'($past(rid_ff))])
      else $error("mismatch flag not set");
   a_bus_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_CFG && mem_ack_in && mem_err_in) |=>
         flags[FLG_BUS*NUM_REGIONS + int'($past(rid_ff))] && !mem_req_out)
      else $error("bus fault flag not set");
   a_loop_flag: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_ADV && cfg_ff.list_loop &&
       !cfg_ff.end_of_list_marker && !stop_ff &&
       !cfg_ff.loop_flag_disable) |=>
         flags[FLG_LOOP*NUM_REGIONS + int'($past(rid_ff))])
      else $error("loop flag not set");
   a_disable_hold: assert property (@(posedge mclk_in) disable iff (reset_in)
      (state_ff == ST_HASH && hash_done_in &&
       cfg_ff.hash_done_flag_disable &&
       !flags[FLG_DONE*NUM_REGIONS + int'(rid_ff)]) |=>
         !flags[FLG_DONE*NUM_REGIONS + int'($past(rid_ff))])
      else $error("disabled done flag rose");
endmodule : hash_region_descriptor_control

// *** core/integrity_monitor_pkg.sv ***
// Purpose: shared constants and types of the region descriptor walker
// Assumes: 32-bit system bus, AXI4-Lite register access
// Notes: register word offsets are byte addresses
package integrity_monitor_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BASE_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] IEN_OFS = 8'h0c;
   localparam logic [7:0] ICLR_OFS = 8'h10;
   localparam logic [7:0] STATE_OFS = 8'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam logic [31:0] IEN_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Descriptor layout in system memory
   localparam logic [31:0] DESC_CFG_OFS = 32'h0000_0004;
   localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_000c;
   localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
   localparam int CFG_COMPARE_BIT = 0;
   localparam int CFG_WRAP_BIT = 1;
   localparam int CFG_EOM_BIT = 2;
   localparam int CFG_DONE_DIS_BIT = 4;
   localparam int CFG_MISM_DIS_BIT = 5;
   localparam int CFG_BUS_DIS_BIT = 6;
   localparam int CFG_LOOP_DIS_BIT = 7;
   // Flag kinds; status bit = kind * regions + region_index
   localparam int FLG_DONE = 0;
   localparam int FLG_MISMATCH = 1;
   localparam int FLG_BUS = 2;
   localparam int FLG_LOOP = 3;
   localparam int FLG_KINDS = 4;
   // ==========================================================
   // Types
   typedef struct packed {
      logic loop_flag_disable;
      logic bus_fault_flag_disable;
      logic mismatch_flag_disable;
      logic hash_done_flag_disable;
      logic end_of_list_marker;
      logic list_loop;
      logic digest_compare_select;
   } region_cfg_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CFG = 5'h02,
      ST_NEXT = 5'h04,
      ST_HASH = 5'h08,
      ST_ADV = 5'h10
   } walk_state_t;
endpackage : integrity_monitor_pkg

// *** core/region_cfg_decode.sv ***
// Purpose: split a region configuration word into its fields
// Assumes: word read from descriptor base + 0x4 + index * 0x10
// Notes: purely combinational
`timescale 1ns/1ps
module region_cfg_decode
   import integrity_monitor_pkg::*;
(
   input wire logic [31:0] word_in,
   output region_cfg_t cfg_out
);
   assign cfg_out.digest_compare_select = word_in[CFG_COMPARE_BIT];
   assign cfg_out.list_loop = word_in[CFG_WRAP_BIT];
   assign cfg_out.end_of_list_marker = word_in[CFG_EOM_BIT];
   assign cfg_out.hash_done_flag_disable = word_in[CFG_DONE_DIS_BIT];
   assign cfg_out.mismatch_flag_disable = word_in[CFG_MISM_DIS_BIT];
   assign cfg_out.bus_fault_flag_disable = word_in[CFG_BUS_DIS_BIT];
   assign cfg_out.loop_flag_disable = word_in[CFG_LOOP_DIS_BIT];
endmodule : region_cfg_decode

// *** core/region_flag_cell.sv ***
// Purpose: one sticky per-region status flag
// Assumes: set and clear are single-cycle pulses
// Notes: a set in the clear cycle wins
`timescale 1ns/1ps
module region_flag_cell (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic set_in,
   input wire logic disable_in,
   input wire logic clear_in,
   output logic flag_out
);
   logic flag_ff;
   logic nxt_flag;

   always_comb begin
      nxt_flag = flag_ff;
      if (clear_in) begin
         nxt_flag = 1'b0;
      end
      // Inverted enable: a disabled flag never rises
      if (set_in && !disable_in) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_out = flag_ff;
endmodule : region_flag_cell

// *** testbench/hash_region_descriptor_control_bench.sv ***
// Purpose: self-checking bench of the region descriptor walker
// Assumes: descriptor list at 0x40, four regions
// Notes: every bus wait is bounded and ends the run when used up
`timescale 1ns/1ps
module hash_region_descriptor_control_bench;
   import integrity_monitor_pkg::*;
   localparam int NR = 4;
   logic clk, rst, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, maddr, mrd, hreg, err_addr;
   logic [3:0] ws;
   logic [1:0] bresp, rresp;
   logic mreq, mack, merr, hst, hcmp, hdn, hmm, busy, irq, mism, slow;
   int miscompares, cmp_count;
   logic [31:0] hq[$];
   logic [31:0] hc[$];

   hash_region_descriptor_control #(.NUM_REGIONS(NR)) i_dut (
      .mclk_in(clk), .reset_in(rst), .s_axi_awaddr_in(awa),
      .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_r), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rrdy), .mem_req_out(mreq), .mem_addr_out(maddr),
      .mem_rdata_in(mrd), .mem_ack_in(mack), .mem_err_in(merr),
      .hash_start_out(hst), .hash_compare_out(hcmp),
      .hash_region_out(hreg), .hash_done_in(hdn),
      .hash_mismatch_in(hmm), .busy_out(busy), .irq_out(irq));

   region_memory_model i_mem (
      .mclk_in(clk), .reset_in(rst), .mem_req_in(mreq),
      .mem_addr_in(maddr), .mem_rdata_out(mrd), .mem_ack_out(mack),
      .mem_err_out(merr), .hash_start_in(hst), .hash_done_out(hdn),
      .hash_mismatch_out(hmm), .err_addr_in(err_addr),
      .mism_in(mism), .slow_in(slow));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Record every hash request with its region and mode
   always @(posedge clk) begin
      if (hst === 1'b1) begin
         hq.push_back(hreg);
         hc.push_back({31'h0, hcmp});
      end
   end

   // ==========================================================
   // Reporting
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task tmo;
      miscompares++;
      $display("wrong value bus wait expected answer seen none");
      test_done();
   endtask : tmo

   function automatic logic [31:0] sb(input int k, input int r);
      return 32'h1 << (k * NR + r);
   endfunction : sb

   // ==========================================================
   // Register bus
   task axi_wr(input logic [7:0] a, input logic [31:0] d,
               output logic [1:0] r);
      int n;
      logic aw_ok;
      logic w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge clk);
         n++;
         if (!aw_ok && awr === 1'b1) begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (!w_ok && wr_r === 1'b1) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end
      while (bv !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      r = bresp;
      brdy <= 1'b0;
      if (n >= 50) tmo();
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] d,
               output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      while (arr !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      arv <= 1'b0;
      while (rv !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      d = rdat;
      r = rresp;
      rrdy <= 1'b0;
      if (n >= 50) tmo();
   endtask : axi_rd

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk($sformatf("register %h", a), e, d);
   endtask : rdc

   // Fill two descriptors, start, stop a looping walk after 3 hashes
   task run_walk(input logic [31:0] c0, n0, c1, n1);
      int n;
      logic stp;
      n = 0;
      stp = 1'b0;
      i_mem.mem[17] = c0;
      i_mem.mem[19] = n0;
      i_mem.mem[21] = c1;
      i_mem.mem[23] = n1;
      wr(ICLR_OFS, 32'h0000_ffff);
      hq.delete();
      hc.delete();
      wr(CTRL_OFS, 32'h1);
      while (busy !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (busy !== 1'b1) tmo();
      while (busy !== 1'b0 && n < 600) begin
         @(posedge clk);
         n++;
         if (hq.size() == 3 && !stp) begin
            stp = 1'b1;
            wr(CTRL_OFS, 32'h2);
         end
      end
      if (n >= 600) tmo();
   endtask : run_walk

   // ==========================================================
   // Scenarios
   task s_regs;
      logic [31:0] d;
      logic [1:0] r;
      rdc(BASE_OFS, BASE_RST);
      rdc(IEN_OFS, IEN_RST);
      rdc(STAT_OFS, 32'h0);
      axi_wr(8'h18, 32'h1, r);
      chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_rd(8'h18, d, r);
      chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped rdata", 32'h0, d);
      wr(STAT_OFS, 32'hffff_ffff);
      rdc(STAT_OFS, 32'h0);
      wr(BASE_OFS, 32'h0000_0040);
      rdc(BASE_OFS, 32'h0000_0040);
   endtask : s_regs

   task s_seq;
      mism <= 1'b1;
      slow <= 1'b1;
      run_walk(32'h0, 32'h1, 32'h5, 32'h0);
      chk("hash count", 32'h2, hq.size());
      chk("first region", 32'h40, hq[0]);
      chk("second region", 32'h50, hq[1]);
      chk("write back", 32'h0, hc[0]);
      chk("compare", 32'h1, hc[1]);
      rdc(STAT_OFS, sb(FLG_DONE, 1) | sb(FLG_MISMATCH, 1));
      // The interrupt is registered once more after the enable lands
      wr(IEN_OFS, sb(FLG_MISMATCH, 1));
      repeat (2) @(posedge clk);
      chk("irq enabled", 32'h1, {31'h0, irq});
      wr(IEN_OFS, sb(FLG_DONE, 0));
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ICLR_OFS, sb(FLG_MISMATCH, 1));
      wr(IEN_OFS, sb(FLG_MISMATCH, 1));
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdc(STAT_OFS, sb(FLG_DONE, 1));
   endtask : s_seq

   task s_loop;
      mism <= 1'b0;
      slow <= 1'b0;
      run_walk(32'h2, 32'h1, 32'h0, 32'h1);
      chk("loop hash 2", 32'h40, hq[1]);
      chk("loop hash 3", 32'h40, hq[2]);
      rdc(STAT_OFS, sb(FLG_LOOP, 0));
      run_walk(32'h6, 32'h1, 32'h0, 32'h1);
      chk("end hash count", 32'h1, hq.size());
      rdc(STAT_OFS, 32'h0);
   endtask : s_loop

   task s_dis;
      mism <= 1'b1;
      run_walk(32'hf5, 32'h0, 32'h0, 32'h0);
      chk("disabled mode", 32'h1, hc[0]);
      rdc(STAT_OFS, 32'h0);
      err_addr <= 32'h0000_004c;
      run_walk(32'h4, 32'h0, 32'h0, 32'h0);
      rdc(STAT_OFS, sb(FLG_BUS, 0));
      run_walk(32'h44, 32'h0, 32'h0, 32'h0);
      rdc(STAT_OFS, 32'h0);
      err_addr <= 32'hffff_ffff;
   endtask : s_dis

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      {awv, wv, brdy, arv, rrdy, mism, slow} = 7'h0;
      awa = 8'h0;
      ara = 8'h0;
      wd = 32'h0;
      ws = 4'hf;
      err_addr = 32'hffff_ffff;
      miscompares = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      s_regs();
      s_seq();
      s_loop();
      s_dis();
      test_done();
   end
endmodule : hash_region_descriptor_control_bench

// *** testbench/region_memory_model.sv ***
// Purpose: system memory and hash engine beside the descriptor walker
// Assumes: 256-byte window of words, filled by the bench
// Notes: slow_in stretches every answer; released data lines toggle
`timescale 1ns/1ps
module region_memory_model (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic mem_req_in,
   input wire logic [31:0] mem_addr_in,
   output logic [31:0] mem_rdata_out,
   output logic mem_ack_out,
   output logic mem_err_out,
   input wire logic hash_start_in,
   output logic hash_done_out,
   output logic hash_mismatch_out,
   input wire logic [31:0] err_addr_in,
   input wire logic mism_in,
   input wire logic slow_in
);
   // ==========================================================
   // Storage
   logic [31:0] mem [0:63];
   logic [2:0] wait_ff;
   logic [2:0] hwait_ff;
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 32'h0;
      end
   end
   // ==========================================================
   // Answers
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         mem_ack_out <= 1'b0;
         mem_err_out <= 1'b0;
         mem_rdata_out <= 32'h0;
         wait_ff <= 3'h0;
         hwait_ff <= 3'h0;
         hash_done_out <= 1'b0;
         hash_mismatch_out <= 1'b0;
      end else begin
         mem_ack_out <= 1'b0;
         mem_err_out <= 1'b0;
         // Stale data must never pass for a fresh word
         mem_rdata_out <= ~mem_rdata_out;
         if (mem_req_in && !mem_ack_out &&
             wait_ff >= (slow_in ? 3'h3 : 3'h0)) begin
            mem_ack_out <= 1'b1;
            mem_err_out <= (mem_addr_in === err_addr_in);
            mem_rdata_out <= mem[mem_addr_in[7:2]];
            wait_ff <= 3'h0;
         end else if (mem_req_in && !mem_ack_out) begin
            wait_ff <= wait_ff + 3'h1;
         end
         hash_done_out <= (hwait_ff == 3'h1);
         hash_mismatch_out <= (hwait_ff == 3'h1) && mism_in;
         if (hash_start_in) begin
            hwait_ff <= slow_in ? 3'h6 : 3'h2;
         end else if (hwait_ff != 3'h0) begin
            hwait_ff <= hwait_ff - 3'h1;
         end
      end
   end
endmodule : region_memory_model
